/* File: sef_defines.svh */
`ifndef SEF_DEFINES_SVH
`define SEF_DEFINES_SVH

// Register byte offsets on the AHB-Lite slave.
`define SEF_STATUS_OFS 8'h00
`define SEF_CTRL_OFS 8'h04
`define SEF_NVBITS_OFS 8'h08
`define SEF_RXDATA_OFS 8'h0c
`define SEF_TXDATA_OFS 8'h10

// Status register bit positions.
`define SEF_ST_WIP 0
`define SEF_ST_WEL 1
`define SEF_ST_SEL 2
`define SEF_ST_PAUSE 3
`define SEF_ST_STBY 4
`define SEF_ST_REFUSED 5
`define SEF_ST_ABORT 6
`define SEF_ST_RXNEW 7
`define SEF_ST_WLOCK 8

// Control register bit positions.
`define SEF_CT_WEL_SET 0
`define SEF_CT_WEL_CLR 1
`define SEF_CT_WR_ARM 2

// Retained bit positions in the non-volatile register.
`define SEF_NV_LO 0
`define SEF_NV_HI 1
`define SEF_NV_LOCK 2

// Reset values.
`define SEF_NV_RST 3'h0
`define SEF_TX_RST 8'hff
`define SEF_PIN_RST 6'h1a

// Timing: clock period and the internal write cycle.
`define SEF_CLK_NS 25
`define SEF_TW_MS 5
`define SEF_TW_CYC ((`SEF_TW_MS * 1000000) / `SEF_CLK_NS)

`endif

/* File: sef_pkg.sv */
package sef_pkg;

  // Serial link state as the device sees it.
  typedef enum logic [1:0] {
    SEF_UNARMED,
    SEF_IDLE,
    SEF_ACTIVE,
    SEF_PAUSED
  } sef_link_e;

  // Serial shifter state.
  typedef struct packed {
    logic [7:0] rx_sh;
    logic [2:0] bcnt;
    logic [7:0] tx_sh;
    logic dout;
    logic [7:0] rx_byte;
    logic rx_done;
  } sef_shift_s;

  // Front end state: link, write control and bus slave.
  typedef struct packed {
    sef_link_e link;
    logic sclk_q;
    logic hold_q;
    logic sel_q;
    logic write_enable_latch;
    logic write_in_progress;
    logic refused;
    logic abort;
    logic rx_new;
    logic wr_arm;
    logic [2:0] nv;
    logic [7:0] tx_byte;
    logic [7:0] rx_data;
    logic [3:0] byte_cnt;
    logic [31:0] tw_cnt;
    logic miso_oe_n;
    logic standby;
    logic dp_wr;
    logic [7:0] dp_addr;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
  } sef_front_s;

endpackage

/* File: sef_sync.sv */
`timescale 1ns/100ps
// Two-stage synchroniser for pins that come from outside the clock domain.
module sef_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST = '0
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } sef_sync_s;

  sef_sync_s r;
  sef_sync_s n;

  // The first stage feeds only the second stage.
  always_comb begin
    n.s1 = d;
    n.s2 = r.s1;
  end

  // State is frozen while the clock enable is low.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r <= {RST, RST};
    end else if (ce) begin
      r <= n;
    end
  end

  assign q = r.s2;
endmodule

/* File: sef_shift.sv */
`timescale 1ns/100ps
// Byte shifter: samples input on serial rising edges, drives output on falling.
module sef_shift
  import sef_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  input wire logic clr,
  input wire logic rise,
  input wire logic fall,
  input wire logic din,
  input wire logic [7:0] tx_byte,
  output logic dout,
  output logic [7:0] rx_byte,
  output logic rx_done,
  output logic [2:0] bit_cnt
);
  sef_shift_s r;
  sef_shift_s n;

  // Edges only arrive here while the link is active, so a pause keeps the bit position.
  always_comb begin
    n = r;
    n.rx_done = 1'b0;
    if (clr) begin
      n.bcnt = 3'h0; // [RQ18] [RQ17]
      n.rx_sh = 8'h00;
      n.tx_sh = 8'h00;
    end else if (rise) begin
      n.rx_sh = {r.rx_sh[6:0], din}; // [RQ2] [RQ15]
      n.bcnt = r.bcnt + 3'h1;
      if (r.bcnt == 3'h7) begin
        n.rx_byte = {r.rx_sh[6:0], din};
        n.rx_done = 1'b1;
      end
    end else if (fall) begin
      // A byte boundary loads the next byte so its top bit leaves first.
      if (r.bcnt == 3'h0) begin
        n.dout = tx_byte[7]; // [RQ1] [RQ15]
        n.tx_sh = {tx_byte[6:0], 1'b0};
      end else begin
        n.dout = r.tx_sh[7]; // [RQ1]
        n.tx_sh = {r.tx_sh[6:0], 1'b0};
      end
    end
  end

  // One register holds all shifter state.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r <= '0;
    end else if (ce) begin
      r <= n;
    end
  end

  assign dout = r.dout;
  assign rx_byte = r.rx_byte;
  assign rx_done = r.rx_done;
  assign bit_cnt = r.bcnt;
endmodule

/* File: sef_front.sv */
// What the document requires of this block and of its master
// RQ1 - Serial output changes only after falling serial clock edges.
// RQ2 - Serial input is sampled on rising serial clock edges.
// RQ3 - Select high deselects the device and floats the output.
// RQ4 - Deselected means standby unless a write cycle runs; select low is active.
// RQ5 - After power-up, a select falling edge is needed before selection.
// RQ6 - Pause floats the output and ignores serial input and clock.
// RQ7 - Pause may only start while the device is selected.
// RQ8 - Pause keeps bit position and instruction progress for resumption.
// RQ9 - Write lock low refuses memory writes; other operations continue.
// RQ10 - Instructions are ignored until power-on reset is released.
// RQ11 - After power-on reset: standby, deselected, waiting for a select fall.
// RQ12 - Power-on reset clears write enable latch and write in progress.
// RQ13 - Power-on reset keeps status lock and both protect bits.
// RQ14 - Master deselects and lets writes finish before removing power.
// RQ15 - All bytes travel most significant bit first both ways.
// RQ16 - Pause starts and ends only on hold edges while clock is low.
// RQ17 - Deselecting while paused resets the serial interface.
// RQ18 - Each select falling edge clears bit counter and shift register.
//
// Design decisions made here: the register addresses and the AHB-Lite slave port.
`timescale 1ns/100ps
`include "sef_defines.svh"
module sef_front
  import sef_pkg::*;
#(
  parameter int unsigned TW_CYCLES = `SEF_TW_CYC
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic por_n,
  input wire logic sclk,
  input wire logic sel_n,
  input wire logic mosi,
  input wire logic hold_n,
  input wire logic wlock_n,
  output logic miso_o,
  output logic miso_oe_n,
  output logic standby_o
);
  sef_front_s r;
  sef_front_s n;

  // Synchronised pins.
  logic [5:0] pins_s;
  logic sclk_s;
  logic sel_n_s;
  logic mosi_s;
  logic hold_n_s;
  logic wlock_n_s;
  logic por_s;

  // Edge strobes derived from the synchronised pins.
  logic clk_rise;
  logic clk_fall;
  logic hold_fall;
  logic hold_rise;
  logic sel_fall;

  // Shifter hookup.
  logic link_on;
  logic sh_clr;
  logic sh_dout;
  logic [7:0] sh_rx_byte;
  logic sh_rx_done;
  logic [2:0] sh_bit_cnt;

  // Bus request decode.
  logic addr_phase;
  logic [31:0] rd_word;

  // Every pin crosses two flops before the front end looks at it.
  // The price is about three hclk cycles on every serial edge, so the serial clock
  // must run several times slower than hclk for each of its levels to be seen.
  sef_sync #(
    .W(6),
    .RST(`SEF_PIN_RST)
  ) u_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .ce(ce),
    .d({por_n, wlock_n, hold_n, mosi, sel_n, sclk}),
    .q(pins_s)
  );

  assign sclk_s = pins_s[0];
  assign sel_n_s = pins_s[1];
  assign mosi_s = pins_s[2];
  assign hold_n_s = pins_s[3];
  assign wlock_n_s = pins_s[4];
  assign por_s = pins_s[5];

  // Edge detection compares the synchronised level with last cycle's copy.
  // The copies reset to each pin's idle level, so no false edge follows a reset.
  assign clk_rise = sclk_s && !r.sclk_q;
  assign clk_fall = !sclk_s && r.sclk_q;
  assign hold_fall = !hold_n_s && r.hold_q;
  assign hold_rise = hold_n_s && !r.hold_q;
  assign sel_fall = !sel_n_s && r.sel_q;

  // Serial edges reach the shifter only while selected and not paused.
  assign link_on = (r.link == SEF_ACTIVE) && !sel_n_s && por_s; // [RQ6] [RQ10]
  // The shifter is held clear for as long as the link is idle, not only at the select
  // edge, so any kind of deselect leaves it ready for the next frame.
  assign sh_clr = (r.link == SEF_IDLE) || (r.link == SEF_UNARMED); // [RQ18] [RQ17]

  sef_shift u_shift (
    .hclk(hclk),
    .hresetn(hresetn),
    .ce(ce),
    .clr(sh_clr),
    .rise(clk_rise && link_on),
    .fall(clk_fall && link_on),
    .din(mosi_s),
    .tx_byte(r.tx_byte),
    .dout(sh_dout),
    .rx_byte(sh_rx_byte),
    .rx_done(sh_rx_done),
    .bit_cnt(sh_bit_cnt)
  );

  // Read mux; unmapped offsets read as zero.
  // Reads have no side effects here; the receive flag is cleared in the next-state logic.
  always_comb begin
    rd_word = 32'h0000_0000;
    unique case (haddr[7:0])
      `SEF_STATUS_OFS: begin
        rd_word[`SEF_ST_WIP] = r.write_in_progress;
        rd_word[`SEF_ST_WEL] = r.write_enable_latch;
        rd_word[`SEF_ST_SEL] = (r.link == SEF_ACTIVE) || (r.link == SEF_PAUSED);
        rd_word[`SEF_ST_PAUSE] = r.link == SEF_PAUSED;
        rd_word[`SEF_ST_STBY] = r.standby;
        rd_word[`SEF_ST_REFUSED] = r.refused;
        rd_word[`SEF_ST_ABORT] = r.abort;
        rd_word[`SEF_ST_RXNEW] = r.rx_new;
        rd_word[`SEF_ST_WLOCK] = !wlock_n_s;
      end
      `SEF_CTRL_OFS: begin
        rd_word[`SEF_CT_WR_ARM] = r.wr_arm;
      end
      `SEF_NVBITS_OFS: begin
        rd_word[2:0] = r.nv;
      end
      `SEF_RXDATA_OFS: begin
        rd_word[7:0] = r.rx_data;
      end
      `SEF_TXDATA_OFS: begin
        rd_word[7:0] = r.tx_byte;
      end
      default: begin
        rd_word = 32'h0000_0000;
      end
    endcase
  end

  assign addr_phase = hsel && hready && htrans[1];

  // All next-state logic. Software clears come first so hardware sets win.
  always_comb begin
    n = r;
    n.sclk_q = sclk_s;
    n.hold_q = hold_n_s;
    n.sel_q = sel_n_s;
    n.hreadyout = 1'b1;
    n.hresp = 1'b0;

    // Address phase: capture the write target, answer reads at once.
    // Answering with zero wait states means hreadyout never has to drop.
    n.dp_wr = 1'b0;
    if (addr_phase) begin
      n.dp_wr = hwrite;
      n.dp_addr = haddr[7:0];
      if (!hwrite) begin
        n.hrdata = rd_word;
        if (haddr[7:0] == `SEF_RXDATA_OFS) begin
          n.rx_new = 1'b0;
        end
      end
    end

    // Data phase of a write.
    // The offset was latched in the address phase, as haddr may already carry the next request.
    if (r.dp_wr) begin
      unique case (r.dp_addr)
        `SEF_STATUS_OFS: begin
          // Sticky event bits are cleared by writing one.
          if (hwdata[`SEF_ST_REFUSED]) begin
            n.refused = 1'b0;
          end
          if (hwdata[`SEF_ST_ABORT]) begin
            n.abort = 1'b0;
          end
        end
        `SEF_CTRL_OFS: begin
          n.wr_arm = hwdata[`SEF_CT_WR_ARM];
          if (hwdata[`SEF_CT_WEL_CLR]) begin
            n.write_enable_latch = 1'b0;
          end else if (hwdata[`SEF_CT_WEL_SET] && !r.write_in_progress && por_s) begin
            n.write_enable_latch = 1'b1;
          end
        end
        `SEF_NVBITS_OFS: begin
          // A locked status register refuses changes while the lock pin is low.
          if (!(r.nv[`SEF_NV_LOCK] && !wlock_n_s)) begin
            n.nv = hwdata[2:0];
          end
        end
        `SEF_TXDATA_OFS: begin
          n.tx_byte = hwdata[7:0];
        end
        default: begin
          n.tx_byte = r.tx_byte;
        end
      endcase
    end

    // A received byte is handed to software and counted.
    // The counter saturates so a long frame can never wrap to zero and float the output again.
    if (sh_rx_done) begin
      n.rx_data = sh_rx_byte;
      n.rx_new = 1'b1;
      if (r.byte_cnt != 4'hf) begin
        n.byte_cnt = r.byte_cnt + 4'h1;
      end
    end

    // The internal write cycle runs down on its own, even when deselected.
    // Neither deselect nor pause touches the timer, so a started cycle completes unless power-on reset cuts it.
    if (r.write_in_progress) begin
      if (r.tw_cnt <= 32'h0000_0001) begin
        n.write_in_progress = 1'b0;
        n.tw_cnt = 32'h0000_0000;
      end else begin
        n.tw_cnt = r.tw_cnt - 32'h0000_0001;
      end
    end

    // The lock pin held low keeps the write enable latch cleared.
    // Clearing the latch itself, rather than gating its use, lets software see the refusal at once.
    if (!wlock_n_s) begin
      n.write_enable_latch = 1'b0; // [RQ9]
    end

    // Serial link state machine.
    // Pause edges are judged against the synchronised clock, which lags the pin as hold does.
    unique case (r.link)
      SEF_UNARMED: begin
        // Select must be seen high first, so a low level is no selection.
        if (sel_n_s) begin
          n.link = SEF_IDLE; // [RQ5] [RQ11]
        end
      end
      SEF_IDLE: begin
        // Counting restarts with every frame, so each selection begins at its instruction.
        if (sel_fall) begin
          n.link = SEF_ACTIVE; // [RQ4] [RQ5]
          n.byte_cnt = 4'h0;
        end
      end
      SEF_ACTIVE: begin
        if (sel_n_s) begin
          n.link = SEF_IDLE; // [RQ3]
          // Whole bytes and an armed write start a write cycle when allowed.
          if (r.wr_arm && (sh_bit_cnt == 3'h0) && (r.byte_cnt != 4'h0)) begin
            if (r.write_enable_latch && wlock_n_s && !r.write_in_progress) begin
              n.write_in_progress = 1'b1;
              n.write_enable_latch = 1'b0;
              n.tw_cnt = TW_CYCLES;
            end else begin
              // A refused write leaves a sticky flag rather than vanishing silently.
              n.refused = 1'b1; // [RQ9]
            end
          end
        end else if (hold_fall && !sclk_s) begin
          n.link = SEF_PAUSED; // [RQ7] [RQ16]
        end
      end
      SEF_PAUSED: begin
        if (sel_n_s) begin
          // Leaving a pause by deselection throws away the partial instruction.
          n.link = SEF_IDLE; // [RQ17]
          n.abort = 1'b1;
        end else if (hold_rise && !sclk_s) begin
          n.link = SEF_ACTIVE; // [RQ8] [RQ16]
        end
      end
    endcase

    // Power-on reset holds the link off and clears the write latch, write cycle and byte count only.
    // The write timer stops as well; a cycle cut by power loss is not resumed.
    if (!por_s) begin
      n.link = SEF_UNARMED; // [RQ10] [RQ11]
      n.write_enable_latch = 1'b0; // [RQ12]
      n.write_in_progress = 1'b0; // [RQ12]
      n.tw_cnt = 32'h0000_0000;
      n.byte_cnt = 4'h0;
      n.nv = r.nv; // [RQ13]
    end

    // Output drive only while selected, unpaused and past the first byte.
    // The first byte is always an instruction, so nothing is driven while it arrives.
    n.miso_oe_n = !((n.link == SEF_ACTIVE) && (n.byte_cnt != 4'h0)); // [RQ3] [RQ6]
    n.standby = (n.link != SEF_ACTIVE) && (n.link != SEF_PAUSED) && !n.write_in_progress; // [RQ4]
  end

  // One register holds the whole front end; the retained bits reset only with the bus.
  // Hresetn stands for the bus reset; por_n is the device's own power-on reset pin.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r <= '0;
      r.link <= SEF_UNARMED;
      r.sclk_q <= 1'b0;
      r.hold_q <= 1'b1;
      r.sel_q <= 1'b1;
      r.nv <= `SEF_NV_RST;
      r.tx_byte <= `SEF_TX_RST;
      r.miso_oe_n <= 1'b1;
      r.standby <= 1'b1;
      r.hreadyout <= 1'b1;
      r.hresp <= 1'b0;
    end else if (ce) begin
      r <= n;
    end
  end

  // Outputs come straight from flops.
  // The serial data flop sits in the shifter, still a single flop from the pin.
  assign hreadyout = r.hreadyout;
  assign hresp = r.hresp;
  assign hrdata = r.hrdata;
  assign miso_o = sh_dout;
  assign miso_oe_n = r.miso_oe_n;
  assign standby_o = r.standby;
endmodule

/* File: sef_front_checker.sv */
`timescale 1ns/100ps
// Pin-level watcher of the serial front end; sync latency is a few hclk cycles.
module sef_front_checker (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic por_n,
  input wire logic sclk,
  input wire logic sel_n,
  input wire logic hold_n,
  input wire logic miso_o,
  input wire logic miso_oe_n,
  input wire logic standby_o
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // Pause entered while the clock rests low, then held past the sync latency.
  sequence s_pause;
    $fell(hold_n) && !sclk && !sel_n ##1 (!hold_n && !sclk) [*6];
  endsequence
  // Select held high long enough for the synchroniser to see it.
  sequence s_desel;
    sel_n [*5];
  endsequence
  chk_out_float: assert property (s_desel |-> miso_oe_n)
    else $error("output driven while deselected");
  chk_pause_float: assert property (s_pause |-> miso_oe_n)
    else $error("output driven while paused");
  chk_miso_fall: assert property ($changed(miso_o) |-> !sclk)
    else $error("serial out moved while clock high");
  chk_miso_steady: assert property (sclk [*3] |-> $stable(miso_o))
    else $error("serial out unstable in high phase");
  chk_stby_exit: assert property ($fell(standby_o) |-> !sel_n)
    else $error("standby left without select");
  chk_drive_start: assert property ($fell(miso_oe_n) |-> !sel_n && hold_n && por_n)
    else $error("output enabled out of a selection");
  chk_por_quiet: assert property (!por_n [*4] |-> miso_oe_n)
    else $error("output driven during power-on reset");
  chk_por_stby: assert property ($rose(por_n) |-> standby_o)
    else $error("not in standby at power-on release");
endmodule

bind sef_front sef_front_checker sef_front_checker_inst (.hclk(hclk), .hresetn(hresetn), .por_n(por_n),
  .sclk(sclk), .sel_n(sel_n), .hold_n(hold_n), .miso_o(miso_o), .miso_oe_n(miso_oe_n), .standby_o(standby_o));

/* File: sef_spi_mst.sv */
`timescale 1ns/100ps
// Behavioural SPI master; its clock rests low between frames.
module sef_spi_mst (
  input wire logic hclk,
  input wire logic miso_o,
  input wire logic miso_oe_n,
  output logic sclk,
  output logic sel_n,
  output logic mosi,
  output logic hold_n
);
  logic lq = 1'h0;
  logic [7:0] rx = 8'h0;
  // The link rests deselected with its clock low and no pause.
  initial begin
    sclk <= 1'h0;
    sel_n <= 1'h1;
    mosi <= 1'h0;
    hold_n <= 1'h1;
  end
  // A floating line reads as the inverse of its last level, never a stale copy.
  wire logic q = miso_oe_n ? ~lq : miso_o;
  always @(posedge hclk) begin
    if (!miso_oe_n) lq <= miso_o;
  end
  // One 200 ns bit: data moves with the falling edge and is sampled at the rising edge.
  task bit1(input logic b);
    mosi <= b;
    repeat (4) @(posedge hclk);
    sclk <= 1'h1;
    rx <= {rx[6:0], q};
    repeat (4) @(posedge hclk);
    sclk <= 1'h0;
  endtask
  task xfer(input logic [7:0] d, input int n);
    for (int i = 0; i < n; i++) bit1(d[7-i]);
  endtask
  // Select edges only with the clock low; frames end deselected.
  task sel(input logic v);
    @(posedge hclk) sel_n <= v;
    repeat (8) @(posedge hclk);
  endtask
  // Pause moves only with the clock low; it starts only with the device selected.
  task hold(input logic v);
    @(posedge hclk) hold_n <= v;
    repeat (8) @(posedge hclk);
  endtask
endmodule

/* File: sef_front_tb.sv */
`timescale 1ns/100ps
`include "sef_defines.svh"
module sef_front_tb;
  localparam int TW = 50;
  logic hclk = 1'h0;
  logic hresetn, hsel, hwrite, por_n, wlock_n, ce;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic [31:0] v;
  logic hreadyout, hresp, sclk, sel_n, mosi, hold_n, miso_o, miso_oe_n, standby_o;
  int fails = 0;
  int samples_checked = 0;
  always #12.5 hclk = ~hclk;
  // Every input of the block except hready, which is fed back from hreadyout, is driven by the bench.
  sef_front #(.TW_CYCLES(TW)) sef_front_inst (.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .por_n(por_n), .sclk(sclk), .sel_n(sel_n),
    .mosi(mosi), .hold_n(hold_n), .wlock_n(wlock_n), .miso_o(miso_o), .miso_oe_n(miso_oe_n),
    .standby_o(standby_o));
  sef_spi_mst sef_spi_mst_inst (.hclk(hclk), .miso_o(miso_o), .miso_oe_n(miso_oe_n), .sclk(sclk),
    .sel_n(sel_n), .mosi(mosi), .hold_n(hold_n));
  task chk(input logic [31:0] seen, input logic [31:0] exp, input string nm);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // One single transfer; the address phase is held until hready is seen high.
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'h1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'h1);
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'h1);
    v = hrdata;
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e, input string nm);
    bus(1'h0, a, 32'h0);
    chk(v, e, nm);
  endtask
  task test_done;
    if (fails == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task t_reset;
    chk(miso_oe_n, 1'h1, "oe_n");
    chk(hresp, 1'h0, "hresp");
    rd(`SEF_STATUS_OFS, 32'h10, "status");
    rd(`SEF_TXDATA_OFS, 32'hff, "txdata");
    rd(8'h14, 32'h0, "unmapped");
  endtask
  // Select driven low while power-on reset is held and kept low through the reset release.
  task t_por;
    sef_spi_mst_inst.sel(1'h0);
    sef_spi_mst_inst.xfer(8'ha5, 8);
    por_n <= 1'h1;
    sef_spi_mst_inst.xfer(8'h5a, 8);
    rd(`SEF_RXDATA_OFS, 32'h0, "rx ignored");
    rd(`SEF_STATUS_OFS, 32'h10, "unselected");
    sef_spi_mst_inst.sel(1'h1);
  endtask
  // A dropped partial byte, then two bytes with read-back on the output.
  task t_byte;
    bus(1'h1, `SEF_TXDATA_OFS, 32'h3c);
    sef_spi_mst_inst.sel(1'h0);
    sef_spi_mst_inst.xfer(8'hff, 3);
    sef_spi_mst_inst.sel(1'h1);
    sef_spi_mst_inst.sel(1'h0);
    sef_spi_mst_inst.xfer(8'ha5, 8);
    rd(`SEF_STATUS_OFS, 32'h84, "active");
    sef_spi_mst_inst.xfer(8'hc3, 8);
    chk(sef_spi_mst_inst.rx, 8'h3c, "miso byte");
    rd(`SEF_RXDATA_OFS, 32'hc3, "rxdata");
    sef_spi_mst_inst.sel(1'h1);
    chk(miso_oe_n, 1'h1, "oe_n idle");
    rd(`SEF_STATUS_OFS, 32'h10, "idle");
  endtask
  // A write while the clock enable is low must not land.
  task t_freeze;
    ce <= 1'h0;
    bus(1'h1, `SEF_TXDATA_OFS, 32'h77);
    ce <= 1'h1;
    rd(`SEF_TXDATA_OFS, 32'h3c, "frozen");
  endtask
  // Pause mid-byte with clocks during it, then deselect while paused.
  task t_pause;
    sef_spi_mst_inst.sel(1'h0);
    sef_spi_mst_inst.xfer(8'h96, 4);
    sef_spi_mst_inst.hold(1'h0);
    rd(`SEF_STATUS_OFS, 32'h0c, "paused");
    sef_spi_mst_inst.xfer(8'hff, 3);
    sef_spi_mst_inst.hold(1'h1);
    sef_spi_mst_inst.xfer(8'h60, 4);
    rd(`SEF_RXDATA_OFS, 32'h96, "resumed");
    sef_spi_mst_inst.hold(1'h0);
    chk(miso_oe_n, 1'h1, "oe_n paused");
    sef_spi_mst_inst.sel(1'h1);
    rd(`SEF_STATUS_OFS, 32'h50, "abort");
    bus(1'h1, `SEF_STATUS_OFS, 32'h40);
    sef_spi_mst_inst.hold(1'h1);
    sef_spi_mst_inst.sel(1'h0);
    sef_spi_mst_inst.xfer(8'h5a, 8);
    rd(`SEF_RXDATA_OFS, 32'h5a, "fresh");
    sef_spi_mst_inst.sel(1'h1);
  endtask
  // Armed write refused under lock, then accepted and timed.
  task t_wlock;
    // The lock pin reaches the logic through the synchroniser, so let it settle.
    wlock_n <= 1'h0;
    repeat (3) @(posedge hclk);
    bus(1'h1, `SEF_CTRL_OFS, 32'h5);
    rd(`SEF_STATUS_OFS, 32'h110, "wel locked");
    sef_spi_mst_inst.sel(1'h0);
    sef_spi_mst_inst.xfer(8'h02, 8);
    sef_spi_mst_inst.sel(1'h1);
    rd(`SEF_STATUS_OFS, 32'h1b0, "refused");
    bus(1'h1, `SEF_STATUS_OFS, 32'h20);
    rd(`SEF_RXDATA_OFS, 32'h02, "locked rx");
    wlock_n <= 1'h1;
    repeat (3) @(posedge hclk);
    bus(1'h1, `SEF_CTRL_OFS, 32'h5);
    sef_spi_mst_inst.sel(1'h0);
    sef_spi_mst_inst.xfer(8'h02, 8);
    sef_spi_mst_inst.sel(1'h1);
    rd(`SEF_STATUS_OFS, 32'h81, "writing");
    chk(standby_o, 1'h0, "standby busy");
    repeat (TW) @(posedge hclk);
    rd(`SEF_STATUS_OFS, 32'h90, "written");
    rd(`SEF_RXDATA_OFS, 32'h02, "rx");
    bus(1'h1, `SEF_CTRL_OFS, 32'h0);
  endtask
  // Power-on reset clears volatile bits and keeps retained ones.
  task t_keep;
    bus(1'h1, `SEF_NVBITS_OFS, 32'h7);
    bus(1'h1, `SEF_CTRL_OFS, 32'h1);
    rd(`SEF_STATUS_OFS, 32'h12, "wel set");
    por_n <= 1'h0;
    repeat (6) @(posedge hclk);
    rd(`SEF_STATUS_OFS, 32'h10, "por status");
    rd(`SEF_NVBITS_OFS, 32'h7, "nv kept");
    por_n <= 1'h1;
    repeat (4) @(posedge hclk);
    wlock_n <= 1'h0;
    repeat (3) @(posedge hclk);
    bus(1'h1, `SEF_NVBITS_OFS, 32'h0);
    rd(`SEF_NVBITS_OFS, 32'h7, "nv locked");
    wlock_n <= 1'h1;
  endtask
  initial begin
    hresetn <= 1'h0;
    hsel <= 1'h0;
    hwrite <= 1'h0;
    hsize <= 3'h2;
    htrans <= 2'h0;
    haddr <= 32'h0;
    hwdata <= 32'h0;
    ce <= 1'h1;
    por_n <= 1'h0;
    wlock_n <= 1'h1;
    repeat (5) @(posedge hclk);
    hresetn <= 1'h1;
    @(posedge hclk);
    t_reset;
    t_por;
    t_byte;
    t_freeze;
    t_pause;
    t_wlock;
    t_keep;
    test_done;
  end
  // The whole sequence needs some 900 cycles; this leaves ample margin.
  initial begin
    #500000;
    fails++;
    test_done;
  end
endmodule
